// *** shared/sfd_pkg.sv ***
// constants and types of the side-band fifo dma read-out
package sfd_pkg;
  // ------------------------------------------------------------
  // register indices and byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] SFD_IDX_CMD = 8'h64;
  localparam logic [7:0] SFD_IDX_STS = 8'h6E;
  localparam logic [11:0] SFD_ADR_CMD = {2'h0, SFD_IDX_CMD, 2'h0};
  localparam logic [11:0] SFD_ADR_STS = {2'h0, SFD_IDX_STS, 2'h0};
  localparam logic [11:0] SFD_ADR_CTRL = 12'h200;
  localparam logic [11:0] SFD_ADR_DIV = 12'h204;
  localparam logic [11:0] SFD_ADR_NTFY = 12'h208;
  localparam logic [11:0] SFD_ADR_BASE = 12'h20C;
  localparam logic [11:0] SFD_ADR_LEN = 12'h210;
  localparam logic [11:0] SFD_ADR_TMO = 12'h214;
  localparam logic [11:0] SFD_ADR_MASK = 12'h218;
  localparam logic [11:0] SFD_ADR_POLL = 12'h21C;
  localparam logic [11:0] SFD_ADR_LVL = 12'h220;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SFD_CMD_START = 20;
  localparam int SFD_CMD_WAIT = 21;
  localparam int SFD_CMD_ABORT = 22;
  localparam int SFD_CMD_POLL = 23;
  localparam int SFD_STS_BLK = 12;
  localparam int SFD_STS_DONE = 13;
  localparam int SFD_STS_OVF = 14;
  localparam int SFD_STS_FLT = 15;
  localparam int SFD_STS_TMO = 16;
  localparam int SFD_STS_RUN = 17;
  localparam int SFD_CTRL_DUAL = 0;
  localparam int SFD_TAG_TS = 31;
  localparam logic [31:0] SFD_STS_STICKY = 32'h0001_F000;
  localparam logic [31:0] SFD_WORD_BYTES = 32'h0000_0004;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] SFD_RST_DIV = 32'h0000_0001;
  localparam logic [31:0] SFD_RST_ZERO = 32'h0000_0000;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SFD_IDLE, SFD_RUN, SFD_POLL, SFD_HALT} sfd_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } sfd_wb_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } sfd_beat_t;
endpackage

// *** logic/sfd_rate_div.sv ***
// slow sample strobe divider
`timescale 1ns/1ps
module sfd_rate_div (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // fast strobe and divider
  input wire logic en_i,
  input wire logic [31:0] div_i,
  // slow strobe
  output logic pulse_o
);
  import sfd_pkg::*;
  logic [31:0] cnt_ff, nxt_cnt;
  logic pulse_ff, nxt_pulse;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_pulse = 1'b0;
    if (en_i) begin
      if (cnt_ff + 32'h0000_0001 >= div_i) begin
        nxt_cnt = SFD_RST_ZERO;
        nxt_pulse = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_ff <= SFD_RST_ZERO;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse_o = pulse_ff;

  a_div_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    pulse_o |-> $past(en_i)) else $error("slow strobe without fast strobe");
endmodule // sfd_rate_div

// *** logic/sfd_fifo.sv ***
// side-band fifo in flip-flops
`timescale 1ns/1ps
module sfd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  output logic in_ready_o,
  // drain side
  input wire logic pop_i,
  output logic out_valid_o,
  output logic [W-1:0] data_o,
  // fill level
  output logic [$clog2(DEPTH):0] level_o
);
  import sfd_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  always_comb begin
    do_push = push_i && (cnt_ff != (AW+1)'(DEPTH));
    do_pop = pop_i && (cnt_ff != '0);
    nxt_wp = do_push ? AW'((wp_ff + 1'b1) % DEPTH) : wp_ff;
    nxt_rp = do_pop ? AW'((rp_ff + 1'b1) % DEPTH) : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
    if (do_push) begin
      mem_ff[wp_ff] <= data_i;
    end
  end

  assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_ff != '0;
  assign data_o = mem_ff[rp_ff];
  assign level_o = cnt_ff;

  a_fifo_full: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (push_i && !in_ready_o && !pop_i) |=> level_o == $past(level_o)) else $error("push into full fifo stored");
endmodule // sfd_fifo

// *** logic/sfd_side_dma.sv ***
// side-band fifo and its read-out dma engine
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module sfd_side_dma #(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register bus
  input wire sfd_pkg::sfd_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // acquisition side
  input wire logic fast_smp_i,
  input wire logic [15:0] slow_smp_i,
  input wire logic ts_valid_i,
  input wire logic [15:0] ts_data_i,
  input wire logic fault_i,
  // host memory write port
  output sfd_pkg::sfd_beat_t dma_o,
  output logic dma_valid_o,
  input wire logic dma_ready_i,
  // interrupt
  output logic irq_o
);
  import sfd_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sfd_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff, nxt_ctrl, div_ff, nxt_div, ntfy_ff, nxt_ntfy;
  logic [31:0] base_ff, nxt_base, len_ff, nxt_len, tmo_ff, nxt_tmo;
  logic [31:0] mask_ff, nxt_mask, sts_ff, nxt_sts;
  logic [31:0] iss_ff, nxt_iss, xfer_ff, nxt_xfer, blk_ff, nxt_blk, tcnt_ff, nxt_tcnt;
  logic [31:0] rdat_ff, nxt_rdat;
  logic ack_ff, nxt_ack, wait_ff, nxt_wait, irq_ff, nxt_irq;
  logic valid_ff, nxt_valid, pend_ff, nxt_pend;
  logic [15:0] hold_ff, nxt_hold;
  sfd_beat_t beat_ff, nxt_beat;
  logic req, wr, rd, wrel, accept, push, pop, ovf;
  logic [31:0] cmd, set, push_data;
  logic slow_pulse, fifo_rdy, fifo_vld;
  logic [31:0] fifo_data;
  logic [$clog2(DEPTH):0] level;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // slow strobe and fifo
  // ------------------------------------------------------------
  sfd_rate_div u_div (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .en_i(fast_smp_i & ctrl_ff[SFD_CTRL_DUAL]),
    .div_i(div_ff),
    .pulse_o(slow_pulse)
  );

  sfd_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .push_i(push),
    .data_i(push_data),
    .in_ready_o(fifo_rdy),
    .pop_i(pop),
    .out_valid_o(fifo_vld),
    .data_o(fifo_data),
    .level_o(level)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_div = div_ff;
    nxt_ntfy = ntfy_ff;
    nxt_base = base_ff;
    nxt_len = len_ff;
    nxt_tmo = tmo_ff;
    nxt_mask = mask_ff;
    nxt_iss = iss_ff;
    nxt_xfer = xfer_ff;
    nxt_blk = blk_ff;
    nxt_tcnt = tcnt_ff;
    nxt_valid = valid_ff;
    nxt_beat = beat_ff;
    nxt_wait = wait_ff;
    nxt_pend = pend_ff;
    nxt_hold = hold_ff;
    nxt_ack = 1'b0;
    nxt_rdat = SFD_RST_ZERO;
    set = SFD_RST_ZERO;
    pop = 1'b0;
    wrel = 1'b0;
    req = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
    wr = req && wb_req_i.we && !wait_ff;
    rd = req && !wb_req_i.we;
    cmd = (wr && wb_req_i.adr == SFD_ADR_CMD && wb_req_i.sel[2]) ? wb_req_i.dat : SFD_RST_ZERO;
    accept = valid_ff && dma_ready_i;

    // slow samples first, a clashing timestamp waits one slot
    push = 1'b0;
    push_data = SFD_RST_ZERO;
    if (slow_pulse) begin
      push = 1'b1;
      push_data = {16'h0000, slow_smp_i};
      if (ts_valid_i && !pend_ff) begin
        nxt_pend = 1'b1;
        nxt_hold = ts_data_i;
      end
    end else if (pend_ff || ts_valid_i) begin
      push = 1'b1;
      push_data = {1'b1, 15'h0000, pend_ff ? hold_ff : ts_data_i};
      nxt_pend = pend_ff && ts_valid_i;
      nxt_hold = ts_data_i;
    end
    ovf = push && !fifo_rdy && ctrl_ff[SFD_CTRL_DUAL];
    if (ovf) begin
      set[SFD_STS_OVF] = 1'b1;
    end

    // dma engine of its own, card to host only
    if (state_ff == SFD_RUN) begin
      if (accept) begin
        nxt_valid = 1'b0;
        nxt_xfer = xfer_ff + SFD_WORD_BYTES;
        if (ntfy_ff != SFD_RST_ZERO && blk_ff + SFD_WORD_BYTES >= ntfy_ff) begin
          set[SFD_STS_BLK] = 1'b1;
          nxt_blk = SFD_RST_ZERO;
        end else begin
          nxt_blk = blk_ff + SFD_WORD_BYTES;
        end
      end
      if (fifo_vld && iss_ff < len_ff && (!valid_ff || dma_ready_i)) begin
        pop = 1'b1;
        nxt_valid = 1'b1;
        nxt_beat.addr = base_ff + iss_ff;
        nxt_beat.data = fifo_data;
        nxt_iss = iss_ff + SFD_WORD_BYTES;
      end
      if (xfer_ff >= len_ff) begin
        nxt_state = SFD_IDLE;
        if (ntfy_ff == SFD_RST_ZERO) begin
          set[SFD_STS_DONE] = 1'b1;
        end
      end
      if (fault_i) begin
        set[SFD_STS_FLT] = 1'b1;
        nxt_state = SFD_HALT;
        nxt_valid = 1'b0;
      end
      if (ovf) begin
        nxt_state = SFD_HALT;
        nxt_valid = 1'b0;
        pop = 1'b0;
      end
    end

    // commands, abort wins over start
    if (cmd[SFD_CMD_ABORT]) begin
      nxt_state = SFD_IDLE;
      nxt_valid = 1'b0;
      pop = 1'b0;
    end else if (cmd[SFD_CMD_START] && (state_ff == SFD_IDLE || state_ff == SFD_HALT)) begin
      nxt_state = SFD_RUN;
      nxt_iss = SFD_RST_ZERO;
      nxt_xfer = SFD_RST_ZERO;
      nxt_blk = SFD_RST_ZERO;
      nxt_valid = 1'b0;
    end else if (cmd[SFD_CMD_POLL] && state_ff == SFD_IDLE) begin
      nxt_state = SFD_POLL;
    end

    // wait holds the bus write until an event or timeout
    if (wait_ff) begin
      nxt_tcnt = tcnt_ff + 32'h0000_0001;
      if (tmo_ff != SFD_RST_ZERO && nxt_tcnt >= tmo_ff) begin
        set[SFD_STS_TMO] = 1'b1;
        wrel = 1'b1;
      end
      if (set[SFD_STS_BLK] || set[SFD_STS_DONE] || nxt_state != SFD_RUN) begin
        wrel = 1'b1;
      end
      if (wrel) begin
        nxt_wait = 1'b0;
        nxt_ack = 1'b1;
      end
    end else if (cmd[SFD_CMD_WAIT] && nxt_state == SFD_RUN) begin
      nxt_wait = 1'b1;
      nxt_tcnt = SFD_RST_ZERO;
    end else if (wr) begin
      nxt_ack = 1'b1;
      case (wb_req_i.adr)
        SFD_ADR_CTRL: nxt_ctrl = wmerge(ctrl_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_DIV: nxt_div = wmerge(div_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_NTFY: nxt_ntfy = wmerge(ntfy_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_BASE: nxt_base = wmerge(base_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_LEN: nxt_len = wmerge(len_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_TMO: nxt_tmo = wmerge(tmo_ff, wb_req_i.dat, wb_req_i.sel);
        SFD_ADR_MASK: nxt_mask = wmerge(mask_ff, wb_req_i.dat, wb_req_i.sel);
        default: nxt_ack = 1'b1;
      endcase
    end else if (rd) begin
      nxt_ack = 1'b1;
      case (wb_req_i.adr)
        SFD_ADR_STS: nxt_rdat = sts_ff | {14'h0000, state_ff == SFD_RUN, 17'h00000};
        SFD_ADR_CTRL: nxt_rdat = ctrl_ff;
        SFD_ADR_DIV: nxt_rdat = div_ff;
        SFD_ADR_NTFY: nxt_rdat = ntfy_ff;
        SFD_ADR_BASE: nxt_rdat = base_ff;
        SFD_ADR_LEN: nxt_rdat = len_ff;
        SFD_ADR_TMO: nxt_rdat = tmo_ff;
        SFD_ADR_MASK: nxt_rdat = mask_ff;
        SFD_ADR_LVL: nxt_rdat = 32'(level);
        SFD_ADR_POLL: begin
          if (state_ff == SFD_POLL && fifo_vld) begin
            pop = 1'b1;
            nxt_rdat = fifo_data;
          end
        end
        default: nxt_rdat = SFD_RST_ZERO;
      endcase
    end

    // sticky status, a new event wins over the read clear
    if (rd && wb_req_i.adr == SFD_ADR_STS) begin
      nxt_sts = (sts_ff & ~SFD_STS_STICKY) | set;
    end else begin
      nxt_sts = sts_ff | set;
    end
    nxt_irq = |(nxt_sts & nxt_mask & SFD_STS_STICKY);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_ff <= SFD_IDLE;
      ctrl_ff <= SFD_RST_ZERO;
      div_ff <= SFD_RST_DIV;
      ntfy_ff <= SFD_RST_ZERO;
      base_ff <= SFD_RST_ZERO;
      len_ff <= SFD_RST_ZERO;
      tmo_ff <= SFD_RST_ZERO;
      mask_ff <= SFD_RST_ZERO;
      sts_ff <= SFD_RST_ZERO;
      iss_ff <= SFD_RST_ZERO;
      xfer_ff <= SFD_RST_ZERO;
      blk_ff <= SFD_RST_ZERO;
      tcnt_ff <= SFD_RST_ZERO;
      rdat_ff <= SFD_RST_ZERO;
      ack_ff <= 1'b0;
      wait_ff <= 1'b0;
      irq_ff <= 1'b0;
      valid_ff <= 1'b0;
      pend_ff <= 1'b0;
      hold_ff <= 16'h0000;
      beat_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      div_ff <= nxt_div;
      ntfy_ff <= nxt_ntfy;
      base_ff <= nxt_base;
      len_ff <= nxt_len;
      tmo_ff <= nxt_tmo;
      mask_ff <= nxt_mask;
      sts_ff <= nxt_sts;
      iss_ff <= nxt_iss;
      xfer_ff <= nxt_xfer;
      blk_ff <= nxt_blk;
      tcnt_ff <= nxt_tcnt;
      rdat_ff <= nxt_rdat;
      ack_ff <= nxt_ack;
      wait_ff <= nxt_wait;
      irq_ff <= nxt_irq;
      valid_ff <= nxt_valid;
      pend_ff <= nxt_pend;
      hold_ff <= nxt_hold;
      beat_ff <= nxt_beat;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign dma_o = beat_ff;
  assign dma_valid_o = valid_ff;
  assign irq_o = irq_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_irq_level: assert property (irq_o == |(sts_ff & mask_ff & SFD_STS_STICKY)) else $error("irq not status and mask");
  a_ovf_halt: assert property (state_ff == SFD_RUN && ovf && !cmd[SFD_CMD_ABORT] |=>
    state_ff == SFD_HALT && sts_ff[SFD_STS_OVF] && !dma_valid_o) else $error("overflow did not halt");
  a_abort_idle: assert property (cmd[SFD_CMD_ABORT] |=>
    state_ff == SFD_IDLE && !dma_valid_o) else $error("abort did not stop transfer");
  a_start_run: assert property (cmd[SFD_CMD_START] && !cmd[SFD_CMD_ABORT] && state_ff != SFD_RUN
    && state_ff != SFD_POLL |=> state_ff == SFD_RUN && xfer_ff == 0) else $error("start did not run");
  a_done_flag: assert property (state_ff == SFD_RUN && xfer_ff >= len_ff && ntfy_ff == 0
    |=> sts_ff[SFD_STS_DONE]) else $error("done not flagged");
  a_done_quiet: assert property (ntfy_ff != 0 && !sts_ff[SFD_STS_DONE] |=>
    !sts_ff[SFD_STS_DONE]) else $error("done flagged with notify size");
  a_blk_flag: assert property (state_ff == SFD_RUN && accept && ntfy_ff != 0 &&
    blk_ff + 4 >= ntfy_ff |=> sts_ff[SFD_STS_BLK] && blk_ff == 0) else $error("block ready missed");
  a_fault_flag: assert property (state_ff == SFD_RUN && fault_i && !cmd[SFD_CMD_ABORT] |=>
    sts_ff[SFD_STS_FLT] && state_ff == SFD_HALT) else $error("fault not flagged");
  a_wait_hold: assert property (wait_ff && !wrel |=> !wb_ack_o && wait_ff) else $error("wait released early");
  a_sts_read: assert property (rd && wb_req_i.adr == SFD_ADR_STS |=> wb_ack_o &&
    wb_dat_o[15:12] == $past(sts_ff[15:12])) else $error("status read wrong");
endmodule // sfd_side_dma

// *** dv/sfd_host_mem.sv ***
// host memory model taking dma write beats
`timescale 1ns/1ps
module sfd_host_mem (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // beat port
  input wire sfd_pkg::sfd_beat_t beat_i,
  input wire logic valid_i,
  output logic ready_o,
  // pacing
  input wire logic slow_i,
  input wire logic hold_i
);
  import sfd_pkg::*;
  sfd_beat_t got_ff [64];
  int n_ff;
  logic tgl_ff;
  // ------------------------------------------------------------
  // acceptance, prompt or every other cycle, none while hold_i is high
  // ------------------------------------------------------------
  assign ready_o = !hold_i && (!slow_i || tgl_ff);
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      n_ff <= 0;
      tgl_ff <= 1'b0;
    end else begin
      tgl_ff <= ~tgl_ff;
      if (valid_i && ready_o) begin
        got_ff[n_ff[5:0]] <= beat_i;
        n_ff <= n_ff + 1;
      end
    end
  end
endmodule // sfd_host_mem

// *** dv/testbench.sv ***
// self-checking bench of the side-band fifo dma read-out
`timescale 1ns/1ps
module testbench;
  import sfd_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  sfd_wb_req_t wb_req = '0;
  logic [31:0] wb_dat;
  logic wb_ack, dv, rdy, irq;
  logic fast = 1'b0, ts_v = 1'b0, fault = 1'b0, slow_m = 1'b0, hold = 1'b0;
  logic [15:0] smp_d = 16'h0000, ts_d = 16'h0000;
  sfd_beat_t beat;
  int err_total = 0, tests_run = 0;
  logic [31:0] x;
  // ------------------------------------------------------------
  // clock, design and host model
  // ------------------------------------------------------------
  always #2 ref_clk_i = ~ref_clk_i;
  sfd_side_dma #(.DEPTH(8)) u_sfd_side_dma (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_req_i(wb_req),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .fast_smp_i(fast), .slow_smp_i(smp_d), .ts_valid_i(ts_v),
    .ts_data_i(ts_d), .fault_i(fault), .dma_o(beat), .dma_valid_o(dv), .dma_ready_i(rdy), .irq_o(irq));
  sfd_host_mem u_sfd_host_mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .beat_i(beat), .valid_i(dv),
    .ready_o(rdy), .slow_i(slow_m), .hold_i(hold));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    @(posedge ref_clk_i);
    while (wb_ack !== 1'b1 && n < 4000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("bus answer", {31'h0, wb_ack}, 32'h1);
    r = wb_dat;
    wb_req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge ref_clk_i) smp_d <= v;
    repeat (3) begin
      @(posedge ref_clk_i) fast <= 1'b1;
      @(posedge ref_clk_i) fast <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
    end
  endtask
  task automatic beat_chk(input int i, input logic [31:0] a, input logic [31:0] d);
    chk("beat addr", u_sfd_host_mem.got_ff[i].addr, a);
    chk("beat data", u_sfd_host_mem.got_ff[i].data & 32'h8000_FFFF, d);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    rd(SFD_ADR_DIV, x);
    chk("div reset", x, SFD_RST_DIV);
    smp(16'h0011);
    rd(SFD_ADR_LVL, x);
    chk("no slow strobe when off", x, 32'h0);
    rd(SFD_ADR_STS, x);
    chk("status reset", x, SFD_RST_ZERO);
    rd(SFD_ADR_CMD, x);
    chk("command reads zero", x, SFD_RST_ZERO);
    rd(12'h300, x);
    chk("unmapped read", x, SFD_RST_ZERO);
    chk("irq reset", {31'h0, irq}, 32'h0);
  endtask
  task automatic s_dma();
    wr(SFD_ADR_CTRL, 32'h1);
    wr(SFD_ADR_DIV, 32'h3);
    for (int k = 0; k < 3; k++) smp(16'h00A0 + 16'(k));
    @(posedge ref_clk_i) ts_d <= 16'h5A5A;
    ts_v <= 1'b1;
    @(posedge ref_clk_i) ts_v <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rd(SFD_ADR_LVL, x);
    chk("fifo level", x, 32'h4);
    wr(SFD_ADR_BASE, 32'h1000);
    wr(SFD_ADR_LEN, 32'h10);
    wr(SFD_ADR_NTFY, 32'h0);
    wr(SFD_ADR_MASK, 32'h2000);
    slow_m <= 1'b1;
    wr(SFD_ADR_CMD, 32'h0030_0000);
    wr(SFD_ADR_CMD, 32'h0020_0000);
    chk("beats after wait", 32'(u_sfd_host_mem.n_ff), 32'h4);
    for (int k = 0; k < 3; k++) beat_chk(k, 32'h1000 + 32'(4 * k), 32'h00A0 + 32'(k));
    beat_chk(3, 32'h100C, 32'h8000_5A5A);
    chk("irq on done", {31'h0, irq}, 32'h1);
    rd(SFD_ADR_STS, x);
    chk("done flag", x & 32'h0002_E000, 32'h2000);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic s_notify();
    for (int k = 0; k < 4; k++) smp(16'h00B0 + 16'(k));
    wr(SFD_ADR_BASE, 32'h2000);
    wr(SFD_ADR_NTFY, 32'h8);
    wr(SFD_ADR_CMD, 32'h0010_0000);
    wr(SFD_ADR_CMD, 32'h0020_0000);
    chk("block seen", {31'h0, u_sfd_host_mem.n_ff >= 6}, 32'h1);
    rd(SFD_ADR_STS, x);
    chk("block flag", x & 32'h3000, 32'h1000);
    for (int n = 0; n < 200 && u_sfd_host_mem.n_ff < 8; n++) @(posedge ref_clk_i);
    for (int k = 0; k < 4; k++) beat_chk(4 + k, 32'h2000 + 32'(4 * k), 32'h00B0 + 32'(k));
    repeat (4) @(posedge ref_clk_i);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rd(SFD_ADR_STS, x);
    chk("no done with notify", x & 32'h0002_2000, 32'h0);
  endtask
  task automatic s_poll_abort();
    smp(16'h00C0);
    wr(SFD_ADR_CMD, 32'h0080_0000);
    rd(SFD_ADR_POLL, x);
    chk("poll word", x & 32'h8000_FFFF, 32'h00C0);
    rd(SFD_ADR_POLL, x);
    chk("poll empty", x, 32'h0);
    wr(SFD_ADR_CMD, 32'h0040_0000);
    wr(SFD_ADR_BASE, 32'h3000);
    wr(SFD_ADR_CMD, 32'h0010_0000);
    rd(SFD_ADR_STS, x);
    chk("running", x & 32'h0002_0000, 32'h0002_0000);
    wr(SFD_ADR_CMD, 32'h0040_0000);
    rd(SFD_ADR_STS, x);
    chk("stopped", x & 32'h0002_0000, 32'h0);
    smp(16'h00C1);
    chk("no beat when idle", {31'h0, dv}, 32'h0);
    chk("beat count", 32'(u_sfd_host_mem.n_ff), 32'h8);
  endtask
  task automatic s_fault();
    hold <= 1'b1;
    wr(SFD_ADR_TMO, 32'h14);
    wr(SFD_ADR_CMD, 32'h0010_0000);
    wr(SFD_ADR_CMD, 32'h0020_0000);
    chk("beat offered", {31'h0, dv}, 32'h1);
    fault <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    fault <= 1'b0;
    chk("beat dropped", {31'h0, dv}, 32'h0);
    rd(SFD_ADR_STS, x);
    chk("fault flag", x & 32'h0002_8000, 32'h8000);
    chk("wait timeout flag", x & 32'h0001_0000, 32'h0001_0000);
    wr(SFD_ADR_CMD, 32'h0040_0000);
  endtask
  task automatic s_overflow();
    wr(SFD_ADR_LEN, 32'h40);
    wr(SFD_ADR_MASK, 32'h4000);
    wr(SFD_ADR_CMD, 32'h0010_0000);
    for (int k = 0; k < 10; k++) smp(16'h00D0 + 16'(k));
    chk("overflow irq", {31'h0, irq}, 32'h1);
    chk("halt drops beat", {31'h0, dv}, 32'h0);
    rd(SFD_ADR_STS, x);
    chk("overflow flag", x & 32'h0002_4000, 32'h4000);
    chk("beat count", 32'(u_sfd_host_mem.n_ff), 32'h8);
  endtask
  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    s_reset();
    s_dma();
    s_notify();
    s_poll_abort();
    s_fault();
    hold <= 1'b1;
    s_overflow();
    close_out();
  end
endmodule // testbench
